// File: hdl/flash_host_pkg.sv
// shared constants and types for the parallel flash command host
package flash_host_pkg;
	localparam int CLK_MHZ = 200;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	localparam int STEP_W = ADDR_W + DATA_W + 2;
	localparam int CNT_W = 5;
	localparam int STATUS_FIVE_BIT = 5;
	localparam int SYNC_STAGES = 2;

	// bus cycle timing in ns, rounded up to whole clocks
	localparam int T_SETUP_NS = 10;
	localparam int T_WE_LOW_NS = 35;
	localparam int T_HOLD_NS = 10;
	localparam int T_READ_NS = 120;
	localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] WE_CYC = CNT_W'((T_WE_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] READ_CYC =
		CNT_W'((T_READ_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES);

	// command words, word-mode addresses
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002AA;
	localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00AA;
	localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
	localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
	localparam logic [DATA_W-1:0] CMD_AUTOSEL = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
	localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
	localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
	localparam logic [DATA_W-1:0] CMD_SECT_ERASE = 16'h0030;
	localparam logic [DATA_W-1:0] CMD_UNPROT = 16'h0060;

	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_WRITE = 4'h1,
		OP_RESET = 4'h2,
		OP_AUTOSEL = 4'h3,
		OP_IDREAD = 4'h4,
		OP_PROGRAM = 4'h5,
		OP_CHIP_ERASE = 4'h6,
		OP_SECT_ERASE = 4'h7,
		OP_UNPROT = 4'h8
	} op_t;

	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_ISSUE = 2'h1,
		M_WAIT = 2'h2
	} main_state_t;

	typedef enum logic [2:0] {
		C_IDLE = 3'h0,
		C_SETUP = 3'h1,
		C_STROBE = 3'h2,
		C_HOLD = 3'h3,
		C_READ = 3'h4
	} cyc_state_t;
endpackage

// File: hdl/flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/10ps
module flash_bus_cycle (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic write_in,
	input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
	input wire logic [flash_host_pkg::DATA_W-1:0] wdata_in,
	input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
	output logic done_out,
	output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
	output logic [flash_host_pkg::ADDR_W-1:0] addr_out,
	output logic [flash_host_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_n_out,
	output logic ce_n_out,
	output logic oe_n_out,
	output logic we_n_out
);
	import flash_host_pkg::*;

	cyc_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
	wire cnt_zero = (cnt_q == {CNT_W{1'b0}});

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end else begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// we stays high through reset so no stray command is taken at power-up
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= C_IDLE;
			cnt_q <= 5'h00;
			ce_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			we_n_out <= 1'b1;
			dq_oe_n_out <= 1'b1;
			addr_out <= 19'h00000;
			dq_out <= 16'h0000;
			rdata_out <= 16'h0000;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			cnt_q <= cnt_zero ? cnt_q : cnt_q - 5'h01;
			case (state_q)
				C_IDLE: if (start_in) begin
					addr_out <= addr_in;
					dq_out <= wdata_in;
					ce_n_out <= 1'b0;
					oe_n_out <= write_in;
					dq_oe_n_out <= !write_in;
					cnt_q <= (write_in ? SETUP_CYC : READ_CYC) - 5'h01;
					state_q <= write_in ? C_SETUP : C_READ;
				end
				C_SETUP: if (cnt_zero) begin
					we_n_out <= 1'b0;
					cnt_q <= WE_CYC - 5'h01;
					state_q <= C_STROBE;
				end
				C_STROBE: if (cnt_zero) begin
					we_n_out <= 1'b1;
					cnt_q <= HOLD_CYC - 5'h01;
					state_q <= C_HOLD;
				end
				C_HOLD: if (cnt_zero) begin
					ce_n_out <= 1'b1;
					dq_oe_n_out <= 1'b1;
					done_out <= 1'b1;
					state_q <= C_IDLE;
				end
				C_READ: if (cnt_zero) begin
					rdata_out <= dq_s2_q;
					ce_n_out <= 1'b1;
					oe_n_out <= 1'b1;
					done_out <= 1'b1;
					state_q <= C_IDLE;
				end
				default: state_q <= C_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	write_strobes_a: assert property (!we_n_out |-> !ce_n_out && oe_n_out)
		else $error("write strobe low without chip select or with output enable");
	read_no_write_a: assert property (!oe_n_out |-> we_n_out && dq_oe_n_out)
		else $error("output enable low during a write");
	we_width_a: assert property ($fell(we_n_out) |-> !we_n_out [*7] ##1 we_n_out)
		else $error("write strobe low time wrong");
	addr_stable_a: assert property (!we_n_out |=> $stable(addr_out))
		else $error("address moved while write strobe low");
	data_hold_a: assert property ($rose(we_n_out) |-> !dq_oe_n_out && $stable(dq_out))
		else $error("data not held at write strobe rise");
endmodule

// File: hdl/flash_command_protection_ctrl.sv
// host controller issuing command sequences to a parallel nor flash
// Functional notes
// - host refuses sector unprotect unless all sectors are protected and temp unprotect is high
// - write needs select and strobe low, oe high
// - host writes reset before the next plain read after status five or autoselect
// - program and erase always start with unlocks
`timescale 1ns/10ps
module flash_command_protection_ctrl (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic op_valid_in,
	input wire flash_host_pkg::op_t op_in,
	input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
	input wire logic [flash_host_pkg::DATA_W-1:0] data_in,
	input wire logic all_protected_in,
	input wire logic temp_unprotect_in,
	input wire logic supply_ok_in,
	input wire logic ready_in,
	input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
	output logic op_ready_out,
	output logic done_out,
	output logic refused_out,
	output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
	output logic autoselect_out,
	output logic fail_out,
	output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_out,
	output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_n_out,
	output logic flash_ce_n_out,
	output logic flash_oe_n_out,
	output logic flash_we_n_out,
	output logic flash_reset_n_out,
	output logic high_voltage_level_out
);
	import flash_host_pkg::*;

	main_state_t state_q, state_d;
	op_t op_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] data_q;
	logic [2:0] idx_q;
	logic autosel_q, fail_q;
	logic [1:0] pin_s1_q, pin_s2_q;
	logic cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	logic [STEP_W-1:0] cur;

	// board pins: bit 0 supply good, bit 1 ready/busy
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_s1_q <= 2'h0;
			pin_s2_q <= 2'h0;
		end else begin
			pin_s1_q <= {ready_in, supply_ok_in};
			pin_s2_q <= pin_s1_q;
		end
	end
	wire supply_ok = pin_s2_q[0];
	wire dev_ready = pin_s2_q[1];

	function automatic logic [STEP_W-1:0] wr(input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d, input logic last);
		return {last, 1'b1, a, d};
	endfunction

	function automatic logic [STEP_W-1:0] rd(input logic [ADDR_W-1:0] a);
		return {1'b1, 1'b0, a, 16'h0000};
	endfunction

	// one bus cycle of a command sequence: {last, write, address, data}
	function automatic logic [STEP_W-1:0] step(input op_t op, input logic [2:0] i,
			input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [STEP_W-1:0] u;
		logic [STEP_W-1:0] s;
		u = (i == 3'h0 || i == 3'h3) ? wr(UNLOCK1_ADDR, UNLOCK1_DATA, 1'b0) :
			wr(UNLOCK2_ADDR, UNLOCK2_DATA, 1'b0);
		s = rd(a);
		case (op)
			OP_READ: s = (i == 3'h0) ? wr(a, CMD_RESET, 1'b0) : rd(a);
			OP_WRITE: s = wr(a, d, 1'b1);
			OP_RESET: s = wr(a, CMD_RESET, 1'b1);
			OP_AUTOSEL: s = (i == 3'h2) ? wr(UNLOCK1_ADDR, CMD_AUTOSEL, 1'b1) : u;
			OP_IDREAD: s = rd(a);
			OP_PROGRAM: s = (i == 3'h2) ? wr(UNLOCK1_ADDR, CMD_PROGRAM, 1'b0) :
				(i == 3'h3) ? wr(a, d, 1'b1) : u;
			OP_CHIP_ERASE: s = (i == 3'h2) ? wr(UNLOCK1_ADDR, CMD_ERASE_SETUP, 1'b0) :
				(i == 3'h5) ? wr(UNLOCK1_ADDR, CMD_CHIP_ERASE, 1'b1) : u;
			OP_SECT_ERASE: s = (i == 3'h2) ? wr(UNLOCK1_ADDR, CMD_ERASE_SETUP, 1'b0) :
				(i == 3'h5) ? wr(a, CMD_SECT_ERASE, 1'b1) : u;
			OP_UNPROT: s = wr(a, CMD_UNPROT, 1'b1);
			default: s = rd(a);
		endcase
		return s;
	endfunction

	assign cur = step(op_q, idx_q, addr_q, data_q);
	wire cyc_last = cur[STEP_W-1];
	wire cyc_write = cur[STEP_W-2];
	wire [ADDR_W-1:0] cyc_addr = cur[DATA_W +: ADDR_W];
	wire [DATA_W-1:0] cyc_data = cur[DATA_W-1:0];
	wire cyc_start = (state_q == M_ISSUE);

	// a read after autoselect or a failure first writes the reset command
	wire needs_reset = autosel_q | fail_q;
	wire read_only = (op_in == OP_IDREAD) || (op_in == OP_READ && !needs_reset);
	wire accept = op_valid_in && op_ready_out;
	wire refuse_now = (!read_only && !supply_ok) ||
		(op_in == OP_IDREAD && !autosel_q) ||
		(op_in == OP_UNPROT && !(all_protected_in && temp_unprotect_in));
	wire take = accept && !refuse_now;
	wire cyc_end = (state_q == M_WAIT) && cyc_done;
	wire clear_flags = cyc_end && cyc_write && (cyc_data == CMD_RESET);
	wire set_fail = cyc_end && !cyc_write && (op_q == OP_READ) && !dev_ready &&
		cyc_rdata[STATUS_FIVE_BIT];

	always_comb begin
		state_d = state_q;
		case (state_q)
			M_IDLE: state_d = take ? M_ISSUE : M_IDLE;
			M_ISSUE: state_d = M_WAIT;
			M_WAIT: if (cyc_done) begin
				state_d = cyc_last ? M_IDLE : M_ISSUE;
			end
			default: state_d = M_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= M_IDLE;
			op_q <= OP_READ;
			addr_q <= 19'h00000;
			data_q <= 16'h0000;
			idx_q <= 3'h0;
		end else begin
			state_q <= state_d;
			if (take) begin
				op_q <= op_in;
				addr_q <= addr_in;
				data_q <= data_in;
				idx_q <= (op_in == OP_READ && !needs_reset) ? 3'h1 : 3'h0;
			end else if (cyc_end && !cyc_last) begin
				idx_q <= idx_q + 3'h1;
			end
		end
	end

	// flag set lands after the clear so a same-cycle set is kept
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			autosel_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			if (clear_flags) begin
				autosel_q <= 1'b0;
				fail_q <= 1'b0;
			end
			if (cyc_end && cyc_last && op_q == OP_AUTOSEL) begin
				autosel_q <= 1'b1;
			end
			if (set_fail) begin
				fail_q <= 1'b1;
			end
		end
	end

	// flash held in hardware reset until our own reset is released
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			op_ready_out <= 1'b1;
			done_out <= 1'b0;
			refused_out <= 1'b0;
			rdata_out <= 16'h0000;
			flash_reset_n_out <= 1'b0;
			high_voltage_level_out <= 1'b0;
		end else begin
			op_ready_out <= (state_d == M_IDLE);
			done_out <= cyc_end && cyc_last;
			refused_out <= accept && refuse_now;
			if (cyc_end && !cyc_write) begin
				rdata_out <= (op_q == OP_IDREAD) ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
			end
			flash_reset_n_out <= 1'b1;
			high_voltage_level_out <= temp_unprotect_in;
		end
	end
	assign autoselect_out = autosel_q;
	assign fail_out = fail_q;

	flash_bus_cycle u_cycle (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(cyc_start),
		.write_in(cyc_write),
		.addr_in(cyc_addr),
		.wdata_in(cyc_data),
		.dq_in(flash_dq_in),
		.done_out(cyc_done),
		.rdata_out(cyc_rdata),
		.addr_out(flash_addr_out),
		.dq_out(flash_dq_out),
		.dq_oe_n_out(flash_dq_oe_n_out),
		.ce_n_out(flash_ce_n_out),
		.oe_n_out(flash_oe_n_out),
		.we_n_out(flash_we_n_out)
	);

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	unprot_refuse_a: assert property (
		accept && op_in == OP_UNPROT && !(all_protected_in && temp_unprotect_in)
		|=> refused_out && state_q == M_IDLE)
		else $error("sector unprotect issued without all sectors protected");
	reset_prefix_a: assert property (
		take && op_in == OP_READ && needs_reset
		|=> cyc_start && cyc_write && cyc_data == CMD_RESET)
		else $error("read after autoselect or failure did not write reset first");
	flags_cleared_a: assert property (clear_flags |=> !autoselect_out && !fail_out)
		else $error("reset command did not clear mode flags");
	unlock_first_a: assert property (
		take && (op_in == OP_PROGRAM || op_in == OP_CHIP_ERASE || op_in == OP_SECT_ERASE)
		|=> cyc_addr == UNLOCK1_ADDR && cyc_data == UNLOCK1_DATA ##1
		(!cyc_done && cyc_data == UNLOCK1_DATA) [*3])
		else $error("program or erase did not open with the unlock write");
	autosel_source_a: assert property ($rose(autoselect_out) |-> $past(op_q) == OP_AUTOSEL)
		else $error("autoselect flag set by a different sequence");
	low_supply_a: assert property (!supply_ok |-> !(take && !read_only))
		else $error("write sequence taken while supply low");
endmodule

// File: bench/flash_array_model.sv
// behavioural parallel nor flash answering the host controller
`timescale 1ns/10ps
module flash_array_model #(
	parameter logic [15:0] PROT_INIT = 16'h0000,
	parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
	parameter logic [7:0] PART_ID = 8'hC3 // arbitrary value
) (
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
	input wire logic [flash_host_pkg::DATA_W-1:0] dq_host_in,
	input wire logic dq_oe_n_in,
	input wire logic reset_n_in,
	input wire logic hv_in,
	input wire logic supply_ok_in,
	output logic [flash_host_pkg::DATA_W-1:0] dq_out,
	output logic ready_out
);
	import flash_host_pkg::*;
	logic [15:0] prot_q = PROT_INIT;
	logic [DATA_W-1:0] mem [64];
	logic [ADDR_W-1:0] la;
	logic [2:0] step;
	logic asel;
	logic armed;
	logic [DATA_W-1:0] last;
	wire drive = !ce_n_in && !oe_n_in && we_n_in;
	wire [7:0] off = addr_in[7:0];
	wire [7:0] id_byte = off == 8'h00 ? MAKER_ID : off == 8'h01 ? PART_ID :
		{7'h00, prot_q[addr_in[18:15]]};
	wire [DATA_W-1:0] rd = asel ? {8'h00, id_byte} : mem[{addr_in[18:15], addr_in[1:0]}];
	// released bus shows the inverse, so a stale value never reads as valid
	assign dq_out = drive ? rd : (!dq_oe_n_in ? dq_host_in : ~last);
	assign ready_out = 1'b1;
	initial begin
		for (int i = 0; i < 64; i++) mem[i] = 16'hFFFF;
		last = '0;
		step = '0;
		asel = 1'b0;
		armed = 1'b0;
	end
	always @(negedge drive) last = rd;
	always @(negedge we_n_in or negedge ce_n_in) begin
		if (!we_n_in && !ce_n_in && oe_n_in) begin
			la = addr_in;
			armed = 1'b1;
		end
	end
	always @(posedge we_n_in or posedge ce_n_in) begin
		if (armed) begin
			armed = 1'b0;
			take(la, dq_out);
		end
	end
	// strobes seen during power-up or low supply never complete a command
	always @(negedge reset_n_in or negedge supply_ok_in) begin
		armed = 1'b0;
		step = '0;
		asel = 1'b0;
	end
	task automatic take(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [3:0] s;
		logic u1;
		logic u2;
		s = a[18:15];
		u1 = a[10:0] == 11'h555;
		u2 = a[10:0] == 11'h2AA && d[7:0] == 8'h55;
		if (!supply_ok_in || !reset_n_in) return;
		if (d[7:0] == 8'hF0) begin
			step = '0;
			asel = 1'b0;
			return;
		end
		if (asel) return;
		case (step)
			3'h0: begin
				if (d[7:0] == 8'h60 && hv_in) prot_q[s] = 1'b0;
				step = (u1 && d[7:0] == 8'hAA) ? 3'h1 : 3'h0;
			end
			3'h1: step = u2 ? 3'h2 : 3'h0;
			3'h2: begin
				step = '0;
				if (u1 && d[7:0] == 8'h90) asel = 1'b1;
				if (u1 && d[7:0] == 8'hA0) step = 3'h3;
				if (u1 && d[7:0] == 8'h80) step = 3'h4;
			end
			3'h3: begin
				if (!prot_q[s] || hv_in) mem[{s, a[1:0]}] = mem[{s, a[1:0]}] & d;
				step = '0;
			end
			3'h4: step = (u1 && d[7:0] == 8'hAA) ? 3'h5 : 3'h0;
			3'h5: step = u2 ? 3'h6 : 3'h0;
			default: begin
				for (int i = 0; i < 64; i++)
					if ((d[7:0] == 8'h10 || (d[7:0] == 8'h30 && i[5:2] == s)) &&
						(!prot_q[i[5:2]] || hv_in)) mem[i] = 16'hFFFF;
				step = '0;
			end
		endcase
	endtask
endmodule

// File: bench/test_flash_command_protection_ctrl.sv
// self-checking bench for the flash command host
`timescale 1ns/10ps
module test_flash_command_protection_ctrl;
	import flash_host_pkg::*;
	localparam logic [7:0] MAKER = 8'h3C;
	localparam logic [7:0] PART = 8'hC3;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic op_valid_in = 1'b0;
	op_t op_in = OP_READ;
	logic [ADDR_W-1:0] addr_in = '0;
	logic [DATA_W-1:0] data_in = '0;
	logic all_prot = 1'b0;
	logic temp_unp = 1'b0;
	logic sup_ok = 1'b1;
	wire ready_w, op_ready_out, done_out, refused_out, autoselect_out, fail_out;
	wire ce_n, oe_n, we_n, dq_oe_n, fl_rst_n, hv;
	wire [DATA_W-1:0] rdata_out, dq_wire, dq_drv;
	wire [ADDR_W-1:0] fl_addr;
	int bad_count = 0;
	int checks = 0;
	always #2.5 clk_in = ~clk_in;
	flash_command_protection_ctrl dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.op_valid_in(op_valid_in), .op_in(op_in), .addr_in(addr_in), .data_in(data_in),
		.all_protected_in(all_prot), .temp_unprotect_in(temp_unp), .supply_ok_in(sup_ok),
		.ready_in(ready_w), .flash_dq_in(dq_wire), .op_ready_out(op_ready_out),
		.done_out(done_out), .refused_out(refused_out), .rdata_out(rdata_out),
		.autoselect_out(autoselect_out), .fail_out(fail_out), .flash_addr_out(fl_addr),
		.flash_dq_out(dq_drv), .flash_dq_oe_n_out(dq_oe_n), .flash_ce_n_out(ce_n),
		.flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .flash_reset_n_out(fl_rst_n),
		.high_voltage_level_out(hv));
	flash_array_model #(.PROT_INIT(16'h0002), .MAKER_ID(MAKER), .PART_ID(PART)) model_u (
		.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(fl_addr),
		.dq_host_in(dq_drv), .dq_oe_n_in(dq_oe_n), .reset_n_in(fl_rst_n), .hv_in(hv),
		.supply_ok_in(sup_ok), .dq_out(dq_wire), .ready_out(ready_w));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic run_op(input op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		while (op_ready_out !== 1'b1 && n < 5000) begin
			@(posedge clk_in);
			#1 n++;
		end
		op_valid_in = 1'b1;
		op_in = o;
		addr_in = a;
		data_in = d;
		@(posedge clk_in);
		#1 op_valid_in = 1'b0;
		while (done_out !== 1'b1 && refused_out !== 1'b1 && n < 5000) begin
			@(posedge clk_in);
			#1 n++;
		end
		if (n >= 5000) begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic rd(input op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		run_op(o, a, 16'h0000);
		chk(rdata_out, e);
	endtask
	task automatic t_program;
		chk(16'(op_ready_out), 16'h0001);
		rd(OP_READ, 19'h00003, 16'hFFFF);
		run_op(OP_PROGRAM, 19'h00003, 16'h1234);
		rd(OP_READ, 19'h00003, 16'h1234);
		run_op(OP_WRITE, UNLOCK1_ADDR, UNLOCK1_DATA);
		run_op(OP_WRITE, UNLOCK2_ADDR, UNLOCK2_DATA);
		run_op(OP_RESET, 19'h00000, 16'h0000);
		run_op(OP_WRITE, UNLOCK1_ADDR, CMD_PROGRAM);
		run_op(OP_WRITE, 19'h00001, 16'h0000);
		rd(OP_READ, 19'h00001, 16'hFFFF);
		$display("program test done");
	endtask
	task automatic t_protect;
		run_op(OP_PROGRAM, 19'h08001, 16'h5A5A);
		rd(OP_READ, 19'h08001, 16'hFFFF);
		temp_unp = 1'b1;
		run_op(OP_PROGRAM, 19'h08001, 16'h5A5A);
		rd(OP_READ, 19'h08001, 16'h5A5A);
		chk(16'(hv), 16'h0001);
		temp_unp = 1'b0;
		run_op(OP_PROGRAM, 19'h08002, 16'h0000);
		rd(OP_READ, 19'h08002, 16'hFFFF);
		run_op(OP_SECT_ERASE, 19'h08000, 16'h0000);
		rd(OP_READ, 19'h08001, 16'h5A5A);
		$display("protect test done");
	endtask
	task automatic t_autoselect;
		run_op(OP_IDREAD, 19'h00000, 16'h0000);
		chk(16'(refused_out), 16'h0001);
		run_op(OP_AUTOSEL, 19'h00000, 16'h0000);
		chk(16'(autoselect_out), 16'h0001);
		rd(OP_IDREAD, 19'h00000, {8'h00, MAKER});
		rd(OP_IDREAD, 19'h00001, {8'h00, PART});
		rd(OP_IDREAD, 19'h08002, 16'h0001);
		rd(OP_IDREAD, 19'h00002, 16'h0000);
		rd(OP_IDREAD, 19'h00000, {8'h00, MAKER});
		run_op(OP_RESET, 19'h7FFFF, 16'h0000);
		chk(16'(autoselect_out), 16'h0000);
		rd(OP_READ, 19'h00003, 16'h1234);
		// plain read straight out of autoselect must lead with a reset write
		run_op(OP_AUTOSEL, 19'h00000, 16'h0000);
		rd(OP_READ, 19'h00003, 16'h1234);
		chk(16'(autoselect_out), 16'h0000);
		chk(16'(fail_out), 16'h0000);
		run_op(OP_SECT_ERASE, 19'h00000, 16'h0000);
		rd(OP_READ, 19'h00003, 16'hFFFF);
		$display("autoselect test done");
	endtask
	task automatic t_unprotect;
		temp_unp = 1'b1;
		run_op(OP_UNPROT, 19'h08000, 16'h0000);
		chk(16'(refused_out), 16'h0001);
		all_prot = 1'b1;
		run_op(OP_UNPROT, 19'h08000, 16'h0000);
		chk(16'(refused_out), 16'h0000);
		temp_unp = 1'b0;
		all_prot = 1'b0;
		run_op(OP_PROGRAM, 19'h08002, 16'h0F0F);
		rd(OP_READ, 19'h08002, 16'h0F0F);
		sup_ok = 1'b0;
		repeat (4) @(posedge clk_in);
		#1 run_op(OP_PROGRAM, 19'h00002, 16'h0000);
		chk(16'(refused_out), 16'h0001);
		sup_ok = 1'b1;
		repeat (4) @(posedge clk_in);
		#1 rd(OP_READ, 19'h00002, 16'hFFFF);
		run_op(OP_CHIP_ERASE, 19'h00000, 16'h0000);
		rd(OP_READ, 19'h08002, 16'hFFFF);
		$display("unprotect and supply test done");
	endtask
	initial begin
		repeat (12) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#1 chk(16'(fl_rst_n), 16'h0001);
		t_program();
		t_protect();
		t_autoselect();
		t_unprotect();
		complete_run();
	end
endmodule
